// ===== mirwl_pkg.sv
// Constants, register map and mode types of the modem interrupt, reset and wake logic
package mirwl_pkg;

	// Core clock and power-up timing
	localparam int unsigned CLK_HZ              = 20000000;
	localparam int unsigned POWERUP_MS          = 10;
	localparam int unsigned POWERUP_CYCLES_DFLT = (POWERUP_MS * (CLK_HZ / 1000));

	// Register addresses as carried in the six address bits of the frame header
	localparam logic [5:0] ADDR_SOFT_RESET = 6'h00;
	localparam logic [5:0] ADDR_IRQ_MASK   = 6'h05;
	localparam logic [5:0] ADDR_PAD_CTRL   = 6'h0C;
	localparam logic [5:0] ADDR_CMP_DIS    = 6'h1B;
	localparam logic [5:0] ADDR_STATUS     = 6'h24;
	localparam logic [5:0] ADDR_RST_IND    = 6'h25;

	// Interrupt status bit positions, shared by the mask register
	localparam int ST_TMR1       = 0;
	localparam int ST_TMR2       = 1;
	localparam int ST_TMR3       = 2;
	localparam int ST_TMR4       = 3;
	localparam int ST_CCA        = 5;
	localparam int ST_TX_SENT    = 6;
	localparam int ST_RX_RCVD    = 7;
	localparam int ST_DOZE       = 9;
	localparam int ST_ATTN       = 10;
	localparam int ST_PLL_UNLOCK = 15;

	// Reset values
	localparam logic [15:0] STATUS_RST  = 16'h0000;
	localparam logic [15:0] MASK_RST    = 16'h0400;
	localparam logic [15:0] PAD_RST     = 16'h0380;
	localparam logic [15:0] CMP_DIS_RST = 16'h0000;

	// Pad control fields
	localparam int PAD_PUP_BIT = 7;
	localparam int PAD_DRV_LSB = 8;

	// Reset indicator field
	localparam int RST_IND_BIT = 7;

	// Frame layout: header byte then one data word, MSB first
	localparam int           FRAME_BITS  = 24;
	localparam int           HEADER_BITS = 8;
	localparam int           HDR_RD_BIT  = 7;
	localparam logic [4:0]   BIT_LAST    = 5'h17;
	localparam logic [4:0]   BIT_HDR_END = 5'h07;

	// Requested transceiver sequences
	localparam logic [1:0] SEQ_TX  = 2'h0;
	localparam logic [1:0] SEQ_RX  = 2'h1;
	localparam logic [1:0] SEQ_CCA = 2'h2;

	typedef enum logic [2:0] {
		MODE_OFF,
		MODE_POWERUP,
		MODE_IDLE,
		MODE_ACTIVE,
		MODE_DOZE,
		MODE_HIBERNATE
	} mirwl_mode_t;

endpackage

// ===== mirwl_core.sv
// Interrupt status, interrupt pin, wake-up, reset and register frame logic of the modem
`timescale 1ns/1ps

// How it works
// RULE1: Timer one, three, four flags set on compare match; cleared by read or disable.
// RULE2: Timer two flag sets on compare two or primed match, not during timed doze.
// RULE3: Interrupt pin pulled low while a request pends, released after status read.
// RULE4: Reading the status register clears every flag it showed.
// RULE5: Pad register bit 7 enables the on-chip interrupt pullup, set after reset.
// RULE6: Two-bit drive field, 00 weakest to 11 strongest, resets to 11.
// RULE7: PLL unlock during a sequence aborts it, returns idle, sets unlock flag.
// RULE8: With unlock flag set, new sequences abort at once; host reads status first.
// RULE9: Receive or assessment aborted by unlock sets no completion flag.
// RULE10: Transmit aborted by unlock still sets the transmit-sent flag.
// RULE11: Reset enables the attention mask; reaching idle after reset sets attention flag.
// RULE12: Attention input wakes from hibernate or doze and sets attention flag.
// RULE13: Host sets attention mask before entering a low-power mode to get wake interrupts.
// RULE14: Attention always ends doze, even with timed exit; reset overrides low power.
// RULE15: With timed exit and outside deep doze, compare two match ends doze and sets the doze flag.
// RULE16: Hard reset low holds powered down; idle follows after power-up delay.
// RULE17: Write to address 00 resets logic and registers, holds powered down, then idle without power-up delay.
// RULE18: Software reset holds while chip enable stays low, releases on chip enable high.
// RULE19: Reset indicator bit 7 of 25 cleared by any reset, kept across low power.
// RULE20: First read of 25 after reset sets the reset indicator until next reset.
// RULE21: Attention flag is bit 10 of status 24, its mask enabled by default.
// RULE22: Compare two match in timed doze, not deep, sets doze flag and returns to idle.
// RULE23: Request pends whenever a status flag is set with its mask bit set.
module mirwl_core
#(
	parameter int unsigned POWERUP_CYCLES = mirwl_pkg::POWERUP_CYCLES_DFLT
)
(
	input  wire logic       ref_clk,
	input  wire logic       srst,
	input  wire logic       hardReset_n,
	input  wire logic       spi_clk,
	input  wire logic       spiCe_n,
	input  wire logic       spiMosi,
	output logic            spiMiso,
	output logic            spiMisoOe,
	output logic            irqOut,
	output logic            irqOe,
	output logic            irqPullupEn,
	output logic [1:0]      irqDrive,
	input  wire logic       attn_n,
	input  wire logic       pllLocked,
	input  wire logic [3:0] cmpMatch,
	input  wire logic       cmpTwoPrimedMatch,
	input  wire logic       seqRequest,
	input  wire logic [1:0] seqKind,
	input  wire logic       seqDone,
	input  wire logic       dozeRequest,
	input  wire logic       dozeDeep,
	input  wire logic       dozeTimerExit,
	input  wire logic       hibernateRequest,
	output logic            seqActive,
	output logic            seqAbort,
	output logic            poweredDown,
	output logic            clkOutRun,
	output logic            inLowPower
);
	import mirwl_pkg::*;

	// Header decode, used in both clock domains
	function automatic logic hdrIsRead(input logic [7:0] hdr);
		hdrIsRead = hdr[HDR_RD_BIT];
	endfunction

	// Link domain state
	logic [4:0]  bitCnt_reg;
	logic [4:0]  bitCnt_next;
	logic [23:0] shift_reg;
	logic [23:0] shift_next;
	logic [7:0]  hdr_reg;
	logic [7:0]  hdr_next;
	logic [23:0] frame_reg;
	logic [23:0] frame_next;
	logic        frameTgl_reg;
	logic        frameTgl_next;
	logic        miso_reg;
	logic        miso_next;
	logic [15:0] rdWord;
	logic [4:0]  outIdx;

	// Core domain synchronisers
	logic [1:0]  ceSync_reg;
	logic [1:0]  hardSync_reg;
	logic [1:0]  pllSync_reg;
	logic [1:0]  attnSync_reg;
	logic [2:0]  tglSync_reg;

	// Core domain state
	mirwl_mode_t mode_reg;
	mirwl_mode_t mode_next;
	logic [17:0] pwrCnt_reg;
	logic [17:0] pwrCnt_next;
	logic        fromHard_reg;
	logic        fromHard_next;
	logic        softRst_reg;
	logic        softRst_next;
	logic [1:0]  kind_reg;
	logic [1:0]  kind_next;
	logic [15:0] status_reg;
	logic [15:0] status_next;
	logic [15:0] mask_reg;
	logic [15:0] mask_next;
	logic [15:0] pad_reg;
	logic [15:0] pad_next;
	logic [15:0] dis_reg;
	logic [15:0] dis_next;
	logic        rstInd_reg;
	logic        rstInd_next;
	logic        abort_reg;
	logic        abort_next;
	logic        irqOe_reg;
	logic [15:0] snapStatus_reg;
	logic [15:0] snapMask_reg;
	logic [15:0] snapPad_reg;
	logic [15:0] snapDis_reg;
	logic        snapInd_reg;

	logic        ceHigh;
	logic        hardLow;
	logic        pllOk;
	logic        attnOn;
	logic        frameEvt;
	logic        frameRead;
	logic [5:0]  frameAddr;
	logic [15:0] frameData;
	logic        coreRst;
	logic [15:0] setVec;
	logic [3:0]  tmrSet;
	logic        timedDoze;
	logic        irqPending;

	// Link side: count bits, shift in, latch header and the whole frame
	always_comb
	begin
		shift_next    = {shift_reg[22:0], spiMosi};
		bitCnt_next   = (bitCnt_reg == BIT_LAST) ? 5'h00 : 5'(bitCnt_reg + 5'h01);
		hdr_next      = (bitCnt_reg == BIT_HDR_END) ? shift_next[7:0] : hdr_reg;
		frame_next    = frame_reg;
		frameTgl_next = frameTgl_reg;
		if (bitCnt_reg == BIT_LAST)
		begin
			frame_next    = shift_next;
			frameTgl_next = ~frameTgl_reg;  // One toggle per complete frame
		end
	end

	// Chip enable high clears the bit counter; the link clock stops between frames
	always_ff @(posedge spi_clk or posedge spiCe_n)
	begin
		if (spiCe_n)
		begin
			bitCnt_reg <= 5'h00;
			shift_reg  <= 24'h000000;
			hdr_reg    <= 8'h00;
		end
		else
		begin
			bitCnt_reg <= bitCnt_next;
			shift_reg  <= shift_next;
			hdr_reg    <= hdr_next;
		end
	end

	// Frame word and its toggle survive chip enable so the core can pick them up
	always_ff @(posedge spi_clk or posedge srst)
	begin
		if (srst)
		begin
			frame_reg    <= 24'h000000;
			frameTgl_reg <= 1'b0;
		end
		else
		begin
			frame_reg    <= frame_next;
			frameTgl_reg <= frameTgl_next;
		end
	end

	// Read word from snapshots frozen by the core for the whole frame
	always_comb
	begin
		rdWord = 16'h0000;
		if (hdr_reg[5:0] == ADDR_STATUS)
			rdWord = snapStatus_reg;
		else if (hdr_reg[5:0] == ADDR_RST_IND)
			rdWord = {8'h00, snapInd_reg, 7'h00};
		else if (hdr_reg[5:0] == ADDR_PAD_CTRL)
			rdWord = snapPad_reg;
		else if (hdr_reg[5:0] == ADDR_IRQ_MASK)
			rdWord = snapMask_reg;
		else if (hdr_reg[5:0] == ADDR_CMP_DIS)
			rdWord = snapDis_reg;
		outIdx    = 5'(BIT_LAST - bitCnt_reg);
		miso_next = 1'b0;
		if (bitCnt_reg >= 5'(HEADER_BITS) && hdrIsRead(hdr_reg))
			miso_next = rdWord[outIdx[3:0]];
	end

	// Launch on the falling edge so the host samples on the rising one
	always_ff @(negedge spi_clk or posedge spiCe_n)
	begin
		if (spiCe_n)
			miso_reg <= 1'b0;
		else
			miso_reg <= miso_next;
	end

	assign spiMiso   = miso_reg;
	assign spiMisoOe = ~spiCe_n;  // Released while not selected

	// Pin and link inputs pass two flip-flops before use
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			ceSync_reg   <= 2'h3;
			hardSync_reg <= 2'h3;  // Idle level, so release shows no false reset
			pllSync_reg  <= 2'h3;
			attnSync_reg <= 2'h3;
			tglSync_reg  <= 3'h0;
		end
		else
		begin
			ceSync_reg   <= {ceSync_reg[0], spiCe_n};
			hardSync_reg <= {hardSync_reg[0], hardReset_n};
			pllSync_reg  <= {pllSync_reg[0], pllLocked};
			attnSync_reg <= {attnSync_reg[0], attn_n};
			tglSync_reg  <= {tglSync_reg[1:0], frameTgl_reg};
		end
	end

	assign ceHigh    = ceSync_reg[1];
	assign hardLow   = ~hardSync_reg[1];
	assign pllOk     = pllSync_reg[1];
	assign attnOn    = ~attnSync_reg[1];
	assign frameEvt  = tglSync_reg[2] ^ tglSync_reg[1];
	assign frameRead = hdrIsRead(frame_reg[23:16]);
	assign frameAddr = frame_reg[21:16];
	assign frameData = frame_reg[15:0];

	// Any of the three resets clears the register file and the mode machine
	assign coreRst   = srst | hardLow | softRst_reg;  // [RULE14] [RULE17]
	assign timedDoze = (mode_reg == MODE_DOZE) && dozeTimerExit && !dozeDeep;

	// Timer flags: one set term per comparator, gated by its disable bit
	generate
		for (genvar i = 0; i < 4; i++)
		begin : gTmr
			if (i == ST_TMR2)
			begin : gTwo
				assign tmrSet[i] = (cmpMatch[i] | cmpTwoPrimedMatch) & ~dis_reg[i]
					& ~timedDoze;  // [RULE2]
			end
			else
			begin : gOther
				assign tmrSet[i] = cmpMatch[i] & ~dis_reg[i];  // [RULE1]
			end
		end
	endgenerate

	// Software reset held from the write until chip enable is seen high
	always_comb
	begin
		softRst_next = softRst_reg;
		if (frameEvt && !frameRead && frameAddr == ADDR_SOFT_RESET)
			softRst_next = 1'b1;  // [RULE17]
		else if (ceHigh)
			softRst_next = 1'b0;  // [RULE18]
	end

	always_ff @(posedge ref_clk)
	begin
		if (srst)
			softRst_reg <= 1'b0;
		else
			softRst_reg <= softRst_next;
	end

	// Mode machine with sequence, abort and wake handling
	always_comb
	begin
		mode_next                = mode_reg;
		pwrCnt_next              = pwrCnt_reg;
		fromHard_next            = fromHard_reg;
		kind_next                = kind_reg;
		abort_next               = 1'b0;
		setVec                   = {12'h000, tmrSet};
		case (mode_reg)
			MODE_OFF:
			begin
				pwrCnt_next = 18'h00000;
				if (fromHard_reg)
					mode_next = MODE_POWERUP;  // [RULE16]
				else
				begin
					mode_next        = MODE_IDLE;
					setVec[ST_ATTN]  = 1'b1;  // [RULE11]
				end
			end
			MODE_POWERUP:
			begin
				pwrCnt_next = 18'(pwrCnt_reg + 18'h00001);
				if (pwrCnt_reg >= 18'(POWERUP_CYCLES - 1))
				begin
					mode_next       = MODE_IDLE;
					fromHard_next   = 1'b0;
					setVec[ST_ATTN] = 1'b1;  // [RULE11] [RULE16]
				end
			end
			MODE_IDLE:
			begin
				if (seqRequest)
				begin
					if (status_reg[ST_PLL_UNLOCK])
						abort_next = 1'b1;  // [RULE8]
					else
					begin
						mode_next = MODE_ACTIVE;
						kind_next = seqKind;
					end
				end
				else if (hibernateRequest)
					mode_next = MODE_HIBERNATE;
				else if (dozeRequest)
					mode_next = MODE_DOZE;
			end
			MODE_ACTIVE:
			begin
				if (!pllOk)
				begin
					mode_next             = MODE_IDLE;  // [RULE7]
					abort_next            = 1'b1;
					setVec[ST_PLL_UNLOCK] = 1'b1;  // [RULE7]
					// Receive and assessment end silently; only transmit reports
					setVec[ST_TX_SENT]    = (kind_reg == SEQ_TX);  // [RULE9] [RULE10]
				end
				else if (seqDone)
				begin
					mode_next          = MODE_IDLE;
					setVec[ST_TX_SENT] = (kind_reg == SEQ_TX);
					setVec[ST_RX_RCVD] = (kind_reg == SEQ_RX);
					setVec[ST_CCA]     = (kind_reg == SEQ_CCA);
				end
			end
			MODE_DOZE:
			begin
				// Attention wins over a simultaneous timer exit
				if (attnOn)
				begin
					mode_next       = MODE_IDLE;  // [RULE14]
					setVec[ST_ATTN] = 1'b1;  // [RULE12]
				end
				else if (timedDoze && cmpMatch[ST_TMR2])
				begin
					mode_next       = MODE_IDLE;  // [RULE22]
					setVec[ST_DOZE] = 1'b1;  // [RULE15] [RULE22]
				end
			end
			MODE_HIBERNATE:
			begin
				if (attnOn)
				begin
					mode_next       = MODE_IDLE;
					setVec[ST_ATTN] = 1'b1;  // [RULE12]
				end
			end
			default:
				mode_next = MODE_OFF;
		endcase
	end

	// Hard reset also remembers that the power-up delay must be served
	always_ff @(posedge ref_clk)
	begin
		if (coreRst)
		begin
			mode_reg     <= MODE_OFF;
			pwrCnt_reg   <= 18'h00000;
			fromHard_reg <= fromHard_reg | srst | hardLow;  // [RULE16]
			kind_reg     <= SEQ_TX;
			abort_reg    <= 1'b0;
		end
		else
		begin
			mode_reg     <= mode_next;
			pwrCnt_reg   <= pwrCnt_next;
			fromHard_reg <= fromHard_next;
			kind_reg     <= kind_next;
			abort_reg    <= abort_next;
		end
	end

	// Register file: writes, read side effects, flag set and clear
	always_comb
	begin
		status_next = status_reg;
		mask_next   = mask_reg;
		pad_next    = pad_reg;
		dis_next    = dis_reg;
		rstInd_next = rstInd_reg;
		if (frameEvt && frameRead && frameAddr == ADDR_STATUS)
			status_next = status_reg & ~snapStatus_reg;  // [RULE4] [RULE3]
		if (frameEvt && frameRead && frameAddr == ADDR_RST_IND)
			rstInd_next = 1'b1;  // [RULE20]
		if (frameEvt && !frameRead)
		begin
			if (frameAddr == ADDR_IRQ_MASK)
				mask_next = frameData;
			else if (frameAddr == ADDR_PAD_CTRL)
				pad_next = frameData;
			else if (frameAddr == ADDR_CMP_DIS)
			begin
				dis_next          = frameData;
				status_next[3:0]  = status_next[3:0] & ~frameData[3:0];  // [RULE1]
			end
		end
		// New events win over any clear in the same cycle
		status_next = status_next | setVec;
	end

	// Low power modes leave every register, the indicator included, untouched
	always_ff @(posedge ref_clk)
	begin
		if (coreRst)
		begin
			status_reg <= STATUS_RST;
			mask_reg   <= MASK_RST;  // [RULE11] [RULE21]
			pad_reg    <= PAD_RST;  // [RULE5] [RULE6]
			dis_reg    <= CMP_DIS_RST;
			rstInd_reg <= 1'b0;  // [RULE19]
		end
		else
		begin
			status_reg <= status_next;
			mask_reg   <= mask_next;
			pad_reg    <= pad_next;
			dis_reg    <= dis_next;
			rstInd_reg <= rstInd_next;
		end
	end

	// Snapshots track while deselected and freeze for the frame, so the
	// link side reads stable words; host waits four core cycles after select
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			snapStatus_reg <= STATUS_RST;
			snapMask_reg   <= MASK_RST;
			snapPad_reg    <= PAD_RST;
			snapDis_reg    <= CMP_DIS_RST;
			snapInd_reg    <= 1'b0;
		end
		else if (ceHigh)
		begin
			snapStatus_reg <= status_reg;
			snapMask_reg   <= mask_reg;
			snapPad_reg    <= pad_reg;
			snapDis_reg    <= dis_reg;
			snapInd_reg    <= rstInd_reg;
		end
	end

	// Interrupt request and open-drain pin, registered to avoid glitches
	assign irqPending = |(status_reg & mask_reg);  // [RULE23]

	always_ff @(posedge ref_clk)
	begin
		if (srst)
			irqOe_reg <= 1'b0;
		else
			irqOe_reg <= irqPending;  // [RULE3]
	end

	assign irqOut      = 1'b0;  // Open drain: only ever drives low
	assign irqOe       = irqOe_reg;
	assign irqPullupEn = pad_reg[PAD_PUP_BIT];  // [RULE5]
	assign irqDrive    = pad_reg[PAD_DRV_LSB +: 2];  // [RULE6]
	assign seqActive   = (mode_reg == MODE_ACTIVE);
	assign seqAbort    = abort_reg;
	assign poweredDown = (mode_reg == MODE_OFF) || (mode_reg == MODE_POWERUP);  // [RULE16]
	assign clkOutRun   = !poweredDown;
	assign inLowPower  = (mode_reg == MODE_DOZE) || (mode_reg == MODE_HIBERNATE);

endmodule // mirwl_core

// ===== mirwl_monitor.sv
// Port checker for the modem interrupt, reset and wake logic
`timescale 1ns/1ps
module mirwl_monitor
#(
	parameter int unsigned POWERUP_CYCLES = 8
)
(
	input logic       ref_clk,
	input logic       srst,
	input logic       hardReset_n,
	input logic       irqOut,
	input logic       irqOe,
	input logic       irqPullupEn,
	input logic [1:0] irqDrive,
	input logic       attn_n,
	input logic       pllLocked,
	input logic       seqRequest,
	input logic       seqDone,
	input logic       seqActive,
	input logic       seqAbort,
	input logic       poweredDown,
	input logic       clkOutRun,
	input logic       inLowPower
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (srst);

	// Power-up window, written for the short count used in simulation
	sequence s_powerup;
		poweredDown [*8] ##[1:4] !poweredDown;
	endsequence
	// Abort lands with the state already idle, and lasts one cycle
	sequence s_abort_idle;
		!seqActive ##1 !seqAbort;
	endsequence

	irq_open_drain_a: assert property (irqOut == 1'h0)
		else $error("irq data not low");
	clk_out_a: assert property (clkOutRun == !poweredDown)
		else $error("clock output not tied to power state");
	pad_reset_a: assert property ($fell(srst) |-> irqPullupEn && irqDrive == 2'h3)
		else $error("pad reset values wrong");
	powerup_time_a: assert property ($fell(srst) && hardReset_n |-> s_powerup)
		else $error("power-up length wrong");
	attn_on_idle_a: assert property ($fell(poweredDown) |-> ##[0:2] irqOe)
		else $error("no request after reset");
	abort_idle_a: assert property (seqAbort |-> s_abort_idle)
		else $error("abort not in idle");
	unlock_abort_a: assert property (seqActive && !pllLocked |-> ##[1:5] seqAbort)
		else $error("unlock did not abort");
	start_refuse_a: assert property (seqRequest && !seqActive && !inLowPower && !poweredDown
		|=> seqActive || seqAbort)
		else $error("request neither started nor refused");
	done_idle_a: assert property (seqActive && seqDone |=> !seqActive)
		else $error("sequence did not end");
	attn_wake_a: assert property ($fell(attn_n) && inLowPower |-> ##[1:5] !inLowPower)
		else $error("attention did not wake");
	hard_hold_a: assert property (!hardReset_n [*5] |-> poweredDown)
		else $error("hard reset not powered down");
endmodule // mirwl_monitor

bind mirwl_core mirwl_monitor #(.POWERUP_CYCLES(POWERUP_CYCLES)) u_mon (.ref_clk, .srst,
	.hardReset_n, .irqOut, .irqOe, .irqPullupEn, .irqDrive, .attn_n, .pllLocked, .seqRequest,
	.seqDone, .seqActive, .seqAbort, .poweredDown, .clkOutRun, .inLowPower);

// ===== mirwl_host_model.sv
// Host model: runs link frames and returns the word read back
`timescale 1ns/1ps
module mirwl_host_model
(
	output logic      spi_clk,
	output logic      spiCe_n,
	output logic      spiMosi,
	input  wire logic spiMiso
);
	// Link clock stands low outside frames
	initial
	begin
		spi_clk = 1'h0;
		spiCe_n = 1'h1;
		spiMosi = 1'h0;
	end

	// One 24-bit frame MSB first; chip enable may be held after the last edge
	task automatic xfer(input logic [7:0] hdr, input logic [15:0] wd, input int hold,
		output logic [15:0] rd);
		logic [23:0] sh;
		sh = {hdr, wd};
		spiCe_n = 1'h0;
		#200;
		for (int i = 23; i >= 0; i--)
		begin
			spiMosi = sh[i];
			#7.5 spi_clk = 1'h1;
			if (i < 16)
				rd[i] = spiMiso;
			#7.5 spi_clk = 1'h0;
		end
		#(hold);
		spiCe_n = 1'h1;
		// Released data line must not keep showing the last bit
		spiMosi = ~spiMosi;
		#250;
	endtask
endmodule // mirwl_host_model

// ===== tb_top.sv
// Self-checking bench for the modem interrupt, reset and wake logic
`timescale 1ns/1ps
module tb_top;
	import mirwl_pkg::*;
	logic       ref_clk = 1'h0;
	logic       srst = 1'h1;
	logic       hardReset_n = 1'h1;
	logic       attn_n = 1'h1;
	logic       pllLocked = 1'h1;
	logic [3:0] cmpMatch = 4'h0;
	logic       cmpTwoPrimedMatch = 1'h0;
	logic       seqRequest = 1'h0;
	logic [1:0] seqKind = 2'h0;
	logic       seqDone = 1'h0;
	logic       dozeRequest = 1'h0;
	logic       dozeDeep = 1'h0;
	logic       dozeTimerExit = 1'h1;
	logic       hibernateRequest = 1'h0;
	logic       spi_clk, spiCe_n, spiMosi, spiMiso, spiMisoOe;
	logic       irqOut, irqOe, irqPullupEn, seqActive, seqAbort;
	logic       poweredDown, clkOutRun, inLowPower;
	logic [1:0] irqDrive;
	logic [15:0] rdw;
	int         n_errors = 0;
	int         n_checks = 0;
	int         cycles = 0;

	mirwl_core #(.POWERUP_CYCLES(8)) dut (.ref_clk, .srst, .hardReset_n, .spi_clk, .spiCe_n,
		.spiMosi, .spiMiso, .spiMisoOe, .irqOut, .irqOe, .irqPullupEn, .irqDrive, .attn_n,
		.pllLocked, .cmpMatch, .cmpTwoPrimedMatch, .seqRequest, .seqKind, .seqDone, .dozeRequest,
		.dozeDeep, .dozeTimerExit, .hibernateRequest, .seqActive, .seqAbort, .poweredDown,
		.clkOutRun, .inLowPower);
	mirwl_host_model host (.spi_clk, .spiCe_n, .spiMosi, .spiMiso);

	// Core clock, 50 ns period
	always #25 ref_clk = ~ref_clk;

	// Hang guard far above the expected run length
	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			n_errors++;
			stop_test();
		end
	end

	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Register access through link frames
	task automatic wr(input logic [5:0] a, input logic [15:0] d);
		host.xfer({2'h0, a}, d, 0, rdw);
	endtask
	task automatic rdc(input string w, input logic [5:0] a, input logic [15:0] e);
		host.xfer({2'h2, a}, 16'h0000, 0, rdw);
		check(w, rdw, e);
	endtask

	// Single-cycle pulse: bits 0-3 compares, 4 primed, 5 done, 6 doze, 7 hibernate
	task automatic pulse(input int w);
		@(negedge ref_clk);
		{hibernateRequest, dozeRequest, seqDone, cmpTwoPrimedMatch, cmpMatch} = 8'h01 << w;
		@(negedge ref_clk);
		{hibernateRequest, dozeRequest, seqDone, cmpTwoPrimedMatch, cmpMatch} = 8'h00;
	endtask
	task automatic seq(input logic [1:0] k);
		@(negedge ref_clk);
		seqRequest = 1'h1;
		seqKind = k;
		@(negedge ref_clk);
		seqRequest = 1'h0;
	endtask
	task automatic waitIrq(input logic e);
		int k;
		for (k = 0; k < 400 && irqOe !== e; k++)
			@(negedge ref_clk);
		check("irqOe", {15'h0000, irqOe}, {15'h0000, e});
	endtask
	task automatic wake();
		@(negedge ref_clk);
		attn_n = 1'h0;
		waitIrq(1'h1);
		attn_n = 1'h1;
		check("awake", {15'h0000, inLowPower}, 16'h0000);
	endtask

	task automatic t_reset();
		waitIrq(1'h1);
		check("pullup", {15'h0000, irqPullupEn}, 16'h0001);
		check("drive", {14'h0000, irqDrive}, 16'h0003);
		rdc("pad", ADDR_PAD_CTRL, 16'h0380);
		rdc("ind0", ADDR_RST_IND, 16'h0000);
		rdc("ind1", ADDR_RST_IND, 16'h0080);
		rdc("mask", ADDR_IRQ_MASK, 16'h0400);
		rdc("attn", ADDR_STATUS, 16'h0400);
		waitIrq(1'h0);
		rdc("clear", ADDR_STATUS, 16'h0000);
		rdc("unmapped", 6'h3F, 16'h0000);
		$display("t_reset done");
	endtask

	task automatic t_timers();
		wr(ADDR_IRQ_MASK, 16'h040F);
		for (int i = 0; i < 5; i++)
		begin
			pulse(i);
			waitIrq(1'h1);
			rdc("timer", ADDR_STATUS, (i == 4) ? 16'h0002 : 16'h0001 << i);
			waitIrq(1'h0);
		end
		pulse(0);
		waitIrq(1'h1);
		wr(ADDR_CMP_DIS, 16'h0001);
		waitIrq(1'h0);
		rdc("disabled", ADDR_STATUS, 16'h0000);
		wr(ADDR_CMP_DIS, 16'h0000);
		$display("t_timers done");
	endtask

	task automatic t_pll();
		logic [15:0] kf [3] = '{16'h0040, 16'h0080, 16'h0020};
		wr(ADDR_IRQ_MASK, 16'h84E0);
		for (int k = 0; k < 3; k++)
		begin
			seq(k[1:0]);
			check("active", {15'h0000, seqActive}, 16'h0001);
			pllLocked = 1'h0;
			for (int n = 0; n < 10 && seqAbort !== 1'h1; n++)
				@(negedge ref_clk);
			check("abort", {15'h0000, seqAbort}, 16'h0001);
			pllLocked = 1'h1;
			seq(k[1:0]);
			check("refused", {14'h0000, seqAbort, seqActive}, 16'h0002);
			rdc("unlock", ADDR_STATUS, (k == 0) ? 16'h8040 : 16'h8000);
		end
		for (int k = 0; k < 3; k++)
		begin
			seq(k[1:0]);
			pulse(5);
			rdc("done", ADDR_STATUS, kf[k]);
		end
		$display("t_pll done");
	endtask

	task automatic t_doze();
		wr(ADDR_IRQ_MASK, 16'h0600);
		pulse(6);
		check("doze", {15'h0000, inLowPower}, 16'h0001);
		pulse(1);
		waitIrq(1'h1);
		check("timed exit", {15'h0000, inLowPower}, 16'h0000);
		rdc("doze flag", ADDR_STATUS, 16'h0200);
		dozeDeep = 1'h1;
		pulse(6);
		pulse(1);
		repeat (6) @(negedge ref_clk);
		check("deep", {15'h0000, inLowPower}, 16'h0001);
		wake();
		rdc("deep attn", ADDR_STATUS, 16'h0402);
		pulse(7);
		check("hib", {15'h0000, inLowPower}, 16'h0001);
		wake();
		rdc("hib attn", ADDR_STATUS, 16'h0400);
		rdc("ind kept", ADDR_RST_IND, 16'h0080);
		$display("t_doze done");
	endtask

	task automatic t_soft();
		wr(ADDR_PAD_CTRL, 16'h0000);
		check("pad off", {13'h0000, irqDrive, irqPullupEn}, 16'h0000);
		fork
			host.xfer(8'h00, 16'h0000, 1000, rdw);
			begin
				#900;
				@(negedge ref_clk);
				check("held", {15'h0000, poweredDown}, 16'h0001);
			end
		join
		waitIrq(1'h1);
		check("pad back", {13'h0000, irqDrive, irqPullupEn}, 16'h0007);
		rdc("ind soft", ADDR_RST_IND, 16'h0000);
		rdc("soft attn", ADDR_STATUS, 16'h0400);
		$display("t_soft done");
	endtask

	task automatic t_hard();
		@(negedge ref_clk);
		hardReset_n = 1'h0;
		repeat (20) @(negedge ref_clk);
		check("off", {14'h0000, poweredDown, clkOutRun}, 16'h0002);
		check("irq off", {15'h0000, irqOe}, 16'h0000);
		hardReset_n = 1'h1;
		waitIrq(1'h1);
		check("clk out", {15'h0000, clkOutRun}, 16'h0001);
		rdc("ind hard", ADDR_RST_IND, 16'h0000);
		rdc("hard attn", ADDR_STATUS, 16'h0400);
		$display("t_hard done");
	endtask

	// Main sequence
	initial
	begin
		repeat (12) @(negedge ref_clk);
		srst = 1'h0;
		t_reset();
		t_timers();
		t_pll();
		t_doze();
		t_soft();
		t_hard();
		stop_test();
	end
endmodule // tb_top
